// ### pit_defines.svh
// Register offsets, field positions and reset values for the timer command decoder.
// Assumes a 32-bit Wishbone slave with word-aligned registers.
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH

`define OFS_CTRL        6'h00
`define OFS_CNT0        6'h04
`define OFS_CNT1        6'h08
`define OFS_CNT2        6'h0c
`define OFS_STAT0       6'h10
`define OFS_STAT1       6'h14
`define OFS_STAT2       6'h18
`define OFS_CFG         6'h1c

`define SEL_HI          7
`define SEL_LO          6
`define RW_HI           5
`define RW_LO           4
`define MODE_HI         3
`define MODE_LO         1
`define BCD_BIT         0
`define RB_NOCOUNT      5
`define RB_NOSTATUS     4
`define RB_SEL_LO       1

`define SEL_READBACK    2'h3
`define RW_LATCH        2'h0
`define CFG_RESET       8'h00
`define MODE_RESET      3'h0
`define RW_RESET        2'h3

`endif

// ### pit_pkg.sv
// Types shared by the timer command decoder files.
// Assumes pit_defines.svh supplies the numeric constants.
package pit_pkg;
    typedef enum logic [2:0] {
        MODE0 = 3'h0, MODE1 = 3'h1, MODE2 = 3'h2,
        MODE3 = 3'h3, MODE4 = 3'h4, MODE5 = 3'h5
    } mode_t;
    typedef enum logic [1:0] {
        RW_LAT = 2'h0, RW_LSB = 2'h1, RW_MSB = 2'h2, RW_BOTH = 2'h3
    } access_t;
    typedef struct packed {
        logic       out;
        logic       null_cnt;
        access_t    rw;
        logic [2:0] mode;
        logic       bcd;
    } status_t;
endpackage

// ### pit_chan_if.sv
// Per-counter command strobes and state passed from the decoder to a channel.
// Assumes one clock domain.
`timescale 1ns/1ps
interface pit_chan_if;
    logic       prog;
    logic [7:0] cmd;
    logic       latch_cnt;
    logic       latch_stat;
    logic       rd_cnt;
    logic       rd_stat;
    logic       count_wr;
    logic       load;
    logic       out;
    logic [15:0] count;
    logic [15:0] cnt_hold;
    logic [7:0] stat_hold;
    logic       cnt_held;
    logic       stat_held;
    modport dec (output prog, cmd, latch_cnt, latch_stat, rd_cnt, rd_stat, count_wr,
                 load, out, count, input cnt_hold, stat_hold, cnt_held, stat_held);
    modport chan (input prog, cmd, latch_cnt, latch_stat, rd_cnt, rd_stat, count_wr,
                  load, out, count, output cnt_hold, stat_hold, cnt_held, stat_held);
endinterface

// ### pit_chan.sv
// One counter's programmed state, null-count flag and latch holding registers.
// Assumes strobes are single-cycle pulses from the decoder on the same clock.
`timescale 1ns/1ps
`include "pit_defines.svh"
module pit_chan
    import pit_pkg::*;
(
    // System
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Decoder side
    pit_chan_if.chan  c
);
    access_t    rw_r;
    logic [2:0] mode_r;
    logic       bcd_r;
    logic       null_r;
    status_t    stat_now;

    // Status assembled from live state
    always_comb begin
        stat_now.out      = c.out;
        stat_now.null_cnt = null_r;
        stat_now.rw       = rw_r;
        stat_now.mode     = mode_r;
        stat_now.bcd      = bcd_r;
    end

    // programmed fields from a control word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rw_r   <= access_t'(`RW_RESET);
            mode_r <= `MODE_RESET;
            bcd_r  <= 1'b0;
        end else if (c.prog) begin
            rw_r   <= access_t'(c.cmd[`RW_HI:`RW_LO]);
            // Don't-care top bit of modes 2 and 3 is stored as written
            mode_r <= c.cmd[`MODE_HI:`MODE_LO];
            bcd_r  <= c.cmd[`BCD_BIT];
        end
    end

    // null count: set wins over a load in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            null_r <= 1'b0;
        end else if (c.prog || c.count_wr) begin
            null_r <= 1'b1;
        end else if (c.load) begin
            null_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c.cnt_held <= 1'b0;
            c.cnt_hold <= 16'h0000;
        end else if (c.rd_cnt) begin
            c.cnt_held <= 1'b0;
        end else if (c.latch_cnt && !c.cnt_held) begin
            c.cnt_held <= 1'b1;
            c.cnt_hold <= c.count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            c.stat_held <= 1'b0;
            c.stat_hold <= 8'h00;
        end else if (c.rd_stat) begin
            c.stat_held <= 1'b0;
        end else if (c.latch_stat && !c.stat_held) begin
            c.stat_held <= 1'b1;
            c.stat_hold <= stat_now;
        end
    end

    chk_null_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (c.prog || c.count_wr) |=> null_r)
        else $error("null count not set after write");
    chk_null_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (c.load && !c.prog && !c.count_wr) |=> !null_r)
        else $error("null count not cleared on load");
    chk_latch_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        (c.cnt_held && !c.rd_cnt) |=> $stable(c.cnt_hold) && c.cnt_held)
        else $error("latched count changed before read");
    chk_mode_prog: assert property (@(posedge clk_i) disable iff (rst_i)
        c.prog |=> mode_r == $past(c.cmd[3:1]) && bcd_r == $past(c.cmd[0]))
        else $error("mode or format not programmed");
endmodule

// ### pit_cmd_decode.sv
// Command decoding and status read-back for a three-counter interval timer.
// Assumes a classic Wishbone master on clk_i; counting logic lives outside and
// reports its count, output level and load strobes on plain ports.
//
// Operation
// - Bits 7:6 select counter 0, 1, 2; value 11 means read-back.
// - Bits 5:4 give access: 00 latch, 01 low, 10 high, 11 both.
// - Bits 3:1 give the counting mode, 0 through 5.
// - Bit 0 set selects BCD counting, clear selects binary.
// - Latch command has bits 5:4 zero; 7:6 pick counter; 3:0 ignored.
// - Read-back bit 5 zero latches count of each selected counter.
// - Read-back bit 4 zero latches status of each selected counter.
// - Read-back bits 3,2,1 zero select counters 2,1,0.
// - Status bit 7 shows the counter output level.
// - Null count sets on control or count write, clears on load.
// - Status bits 5:4 and 3:1 report access size and mode.
// - Status bit 0 reports binary or BCD counting.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "pit_defines.svh"
module pit_cmd_decode
    import pit_pkg::*;
(
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    // Counting logic, same clock
    input  wire logic [2:0]  out_i,
    input  wire logic [47:0] count_i,
    input  wire logic [2:0]  load_i,
    output logic      [2:0]  count_wr_o,
    output logic      [7:0]  status0_o,
    output logic      [7:0]  status1_o,
    output logic      [7:0]  status2_o,
    output logic      [7:0]  cfg_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic        req;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic [7:0]  wbyte;
    logic [2:0]  rb_sel;
    logic [7:0]  cfg_r;
    logic [31:0] rdata_nxt;

    // Single-cycle answer; ack drops the cycle after it was given
    assign req    = cyc_i && stb_i && !ack_o && !err_o;
    assign mapped = (adr_i[1:0] == 2'b00) && (adr_i <= `OFS_CFG);
    assign wr     = req && mapped && we_i && sel_i[0];
    assign rd     = req && mapped && !we_i;
    assign wbyte  = dat_i[7:0];

    // read-back select
    // Inverted: a zero bit chooses the counter
    assign rb_sel = ~wbyte[`MODE_HI:`RB_SEL_LO];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= req && mapped;
            err_o <= req && !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-counter strobes
    pit_chan_if ch [3] ();
    logic [2:0] is_ctrl;
    logic [2:0] is_prog;
    logic [2:0] is_latch;
    logic [2:0] rb_cnt;
    logic [2:0] rb_stat;
    logic [2:0] rd_cnt_hit;
    logic [2:0] rd_stat_hit;
    logic [7:0] stat_live [3];
    logic [15:0] cnt_hold [3];
    logic [7:0] stat_hold [3];
    logic [2:0] cnt_held;
    logic [2:0] stat_held;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ch
            assign is_ctrl[gi] = wr && (adr_i == `OFS_CTRL) && (wbyte[`SEL_HI:`SEL_LO] == 2'(gi));
            // access field; latch when zero, bits 3:0 unused
            assign is_latch[gi] = is_ctrl[gi] && (wbyte[`RW_HI:`RW_LO] == `RW_LATCH);
            assign is_prog[gi]  = is_ctrl[gi] && (wbyte[`RW_HI:`RW_LO] != `RW_LATCH);
            assign rb_cnt[gi]  = wr && (adr_i == `OFS_CTRL) && (wbyte[`SEL_HI:`SEL_LO] == `SEL_READBACK)
                                 && rb_sel[gi] && !wbyte[`RB_NOCOUNT];
            assign rb_stat[gi] = wr && (adr_i == `OFS_CTRL) && (wbyte[`SEL_HI:`SEL_LO] == `SEL_READBACK)
                                 && rb_sel[gi] && !wbyte[`RB_NOSTATUS];
            assign rd_cnt_hit[gi]  = rd && (adr_i == 6'(`OFS_CNT0 + 4 * gi));
            assign rd_stat_hit[gi] = rd && (adr_i == 6'(`OFS_STAT0 + 4 * gi));

            assign ch[gi].prog       = is_prog[gi];
            assign ch[gi].cmd        = wbyte;
            assign ch[gi].latch_cnt  = is_latch[gi] || rb_cnt[gi];
            assign ch[gi].latch_stat = rb_stat[gi];
            assign ch[gi].rd_cnt     = rd_cnt_hit[gi];
            assign ch[gi].rd_stat    = rd_stat_hit[gi];
            assign ch[gi].count_wr   = wr && (adr_i == 6'(`OFS_CNT0 + 4 * gi));
            assign ch[gi].load       = load_i[gi];
            assign ch[gi].out        = out_i[gi];
            assign ch[gi].count      = count_i[16*gi +: 16];
            assign cnt_hold[gi]      = ch[gi].cnt_hold;
            assign stat_hold[gi]     = ch[gi].stat_hold;
            assign cnt_held[gi]      = ch[gi].cnt_held;
            assign stat_held[gi]     = ch[gi].stat_held;
            assign count_wr_o[gi]    = ch[gi].count_wr;

            pit_chan u_chan (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .c     (ch[gi].chan)
            );
        end
    endgenerate

    // Live status; procedural, as a continuous assign would not wake on state read inside the function
    always_comb begin
        stat_live[0] = status_of(0);
        stat_live[1] = status_of(1);
        stat_live[2] = status_of(2);
    end
    assign status0_o = stat_live[0];
    assign status1_o = stat_live[1];
    assign status2_o = stat_live[2];
    assign cfg_o     = cfg_r;

    function automatic logic [7:0] status_of(input int n);
        logic [7:0] s;
        s = 8'h00;
        case (n)
            0: s = u_stat(0);
            1: s = u_stat(1);
            default: s = u_stat(2);
        endcase
        return s;
    endfunction

    function automatic logic [7:0] u_stat(input int n);
        logic [7:0] s;
        s = 8'h00;
        case (n)
            0: s = {out_i[0], g_ch[0].u_chan.null_r, g_ch[0].u_chan.rw_r,
                    g_ch[0].u_chan.mode_r, g_ch[0].u_chan.bcd_r};
            1: s = {out_i[1], g_ch[1].u_chan.null_r, g_ch[1].u_chan.rw_r,
                    g_ch[1].u_chan.mode_r, g_ch[1].u_chan.bcd_r};
            default: s = {out_i[2], g_ch[2].u_chan.null_r, g_ch[2].u_chan.rw_r,
                          g_ch[2].u_chan.mode_r, g_ch[2].u_chan.bcd_r};
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Spare configuration byte, steers nothing but is readable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= `CFG_RESET;
        end else if (wr && adr_i == `OFS_CFG) begin
            cfg_r <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data: held value if latched, else live value
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (adr_i)
            `OFS_CNT0:  rdata_nxt = {15'h0000, cnt_held[0], cnt_held[0] ? cnt_hold[0] : count_i[15:0]};
            `OFS_CNT1:  rdata_nxt = {15'h0000, cnt_held[1], cnt_held[1] ? cnt_hold[1] : count_i[31:16]};
            `OFS_CNT2:  rdata_nxt = {15'h0000, cnt_held[2], cnt_held[2] ? cnt_hold[2] : count_i[47:32]};
            `OFS_STAT0: rdata_nxt = {23'h000000, stat_held[0], stat_held[0] ? stat_hold[0] : stat_live[0]};
            `OFS_STAT1: rdata_nxt = {23'h000000, stat_held[1], stat_held[1] ? stat_hold[1] : stat_live[1]};
            `OFS_STAT2: rdata_nxt = {23'h000000, stat_held[2], stat_held[2] ? stat_hold[2] : stat_live[2]};
            `OFS_CFG:   rdata_nxt = {24'h000000, cfg_r};
            default:    rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd) begin
            dat_o <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Bus ack lasts one cycle
    chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    chk_readback_target: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == 6'h00 && wbyte[7:6] == 2'b11) |-> (is_ctrl == 3'b000))
        else $error("read-back treated as counter select");
    chk_access_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_ctrl[1] && wbyte[5:4] == 2'b00) |-> !is_prog[1] && ch[1].latch_cnt)
        else $error("latch command programmed the counter");
    chk_rb_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == 6'h00 && wbyte[7:6] == 2'b11 && !wbyte[5] && !wbyte[3]) |-> rb_cnt[2])
        else $error("read-back count latch missed");
    chk_rb_status: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == 6'h00 && wbyte[7:6] == 2'b11 && wbyte[4]) |-> (rb_stat == 3'b000))
        else $error("status latched with bit 4 set");
    chk_rb_select: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == 6'h00 && wbyte[7:6] == 2'b11 && wbyte[1] && !wbyte[5]) |-> !rb_cnt[0])
        else $error("unselected counter latched");
    chk_status_out: assert property (@(posedge clk_i) disable iff (rst_i)
        status1_o[7] == out_i[1])
        else $error("status output bit wrong");
    chk_status_fields: assert property (@(posedge clk_i) disable iff (rst_i)
        is_prog[0] |=> status0_o[5:0] == $past(wbyte[5:0]))
        else $error("status fields do not match control word");
    chk_stat_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        (stat_held[2] && !rd_stat_hit[2]) |=> stat_held[2] && $stable(stat_hold[2]))
        else $error("status latch lost before read");

    ////////////////////////////////////////////////////////////////////////////
    // Checks on bus answers, programmed fields, read-back selection and latch holding
    // Bus error pulse lasts one cycle
    chk_err_one: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> !err_o)
        else $error("err held longer than one cycle");
    // Bus answer is ack or err, never both
    chk_answer_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ack_o && err_o))
        else $error("ack and err raised together");
    chk_access_field: assert property (@(posedge clk_i) disable iff (rst_i)
        is_prog[2] |=> status2_o[5:4] == $past(wbyte[5:4]))
        else $error("access size not stored");
    chk_mode_field: assert property (@(posedge clk_i) disable iff (rst_i)
        is_prog[1] |=> status1_o[3:1] == $past(wbyte[3:1]))
        else $error("mode not stored");
    chk_bcd_field: assert property (@(posedge clk_i) disable iff (rst_i)
        is_prog[2] |=> status2_o[0] == $past(wbyte[0]))
        else $error("count format not stored");
    chk_null_status: assert property (@(posedge clk_i) disable iff (rst_i)
        is_prog[0] |=> status0_o[6])
        else $error("null count clear after control word");
    chk_latch_fields: assert property (@(posedge clk_i) disable iff (rst_i)
        is_latch[1] |=> status1_o[5:0] == $past(status1_o[5:0]))
        else $error("latch command changed programmed fields");
    chk_rb_count_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == `OFS_CTRL && wbyte[7:6] == 2'b11 && !wbyte[5] && !wbyte[1]) |-> rb_cnt[0])
        else $error("read-back count latch of counter zero missed");
    chk_rb_count_one: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == `OFS_CTRL && wbyte[7:6] == 2'b11 && !wbyte[5] && !wbyte[2]) |-> rb_cnt[1])
        else $error("read-back count latch of counter one missed");
    chk_rb_status_one: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == `OFS_CTRL && wbyte[7:6] == 2'b11 && !wbyte[4] && !wbyte[2]) |-> rb_stat[1])
        else $error("read-back status latch of counter one missed");
    chk_count_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        (ch[0].latch_cnt && !cnt_held[0]) |=> cnt_held[0] && cnt_hold[0] == $past(count_i[15:0]))
        else $error("count not captured on latch");
    chk_latch_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
        (cnt_held[1] && ch[1].latch_cnt) |=> $stable(cnt_hold[1]))
        else $error("held count overwritten by second latch");
    chk_read_release: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_cnt_hit[2] |=> !cnt_held[2])
        else $error("count latch not released by read");

    cov_program: cover property (@(posedge clk_i) disable iff (rst_i) is_prog[0]);
    cov_latch:   cover property (@(posedge clk_i) disable iff (rst_i) is_latch[2]);
    cov_rb_both: cover property (@(posedge clk_i) disable iff (rst_i) rb_cnt[1] && rb_stat[1]);
    cov_err:     cover property (@(posedge clk_i) disable iff (rst_i) err_o);
endmodule

// ### tb_top.sv
// Self-checking bench for the timer command decoder: table of control words,
// then latch, read-back, null-count and bus refusal cases.
// Assumes the decoder answers each Wishbone request with one ack or err pulse.
`timescale 1ns/1ps
`include "pit_defines.svh"
module tb_top;
    import pit_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Signals
    logic        clk_i;
    logic        rst_i;
    logic        cyc_i;
    logic        stb_i;
    logic        we_i;
    logic [5:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        err_o;
    logic [2:0]  out_i;
    logic [47:0] count_i;
    logic [2:0]  load_i;
    logic [2:0]  count_wr_o;
    logic [7:0]  status0_o;
    logic [7:0]  status1_o;
    logic [7:0]  status2_o;
    logic [7:0]  cfg_o;
    logic [31:0] q;
    logic        e;
    logic [7:0]  s;
    logic [23:0] snap;
    int          fail_count;
    int          n_compared;
    int          wr_seen;

    // Control word, target counter, expected {null, rw, mode, bcd}
    typedef struct packed {
        logic [7:0] cmd;
        logic [1:0] ch;
        logic [6:0] exp;
    } row_t;
    row_t rows [9] = '{
        '{8'h34, 2'h0, 7'h74}, '{8'h53, 2'h1, 7'h53}, '{8'ha6, 2'h2, 7'h66},
        '{8'h3c, 2'h0, 7'h7c}, '{8'h7e, 2'h1, 7'h7e}, '{8'h98, 2'h2, 7'h58},
        '{8'h1a, 2'h0, 7'h5a}, '{8'h70, 2'h1, 7'h70}, '{8'hb1, 2'h2, 7'h71}};

    pit_cmd_decode dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .out_i(out_i), .count_i(count_i), .load_i(load_i),
        .count_wr_o(count_wr_o), .status0_o(status0_o), .status1_o(status1_o),
        .status2_o(status2_o), .cfg_o(cfg_o));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #100us;
        fail_count++;
        tally_and_finish();
    end
    // Count-write strobes for counter 1, seen at the taking edge
    always @(posedge clk_i) begin
        if (count_wr_o === 3'b010) wr_seen++;
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle; request held until ack or err is sampled high
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] m);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= m;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        q = dat_o;
        e = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (n >= 20) fail_count++;
    endtask
    function automatic logic [7:0] stat(input logic [1:0] n);
        return (n == 2'h0) ? status0_o : (n == 2'h1) ? status1_o : status2_o;
    endfunction
    task automatic pulse_load(input logic [2:0] m);
        @(posedge clk_i);
        load_i <= m;
        @(posedge clk_i);
        load_i <= 3'h0;
        @(posedge clk_i);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 6'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        out_i = 3'b101;
        load_i = 3'h0;
        count_i = 48'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset state: both bytes, mode 0, binary, null clear
        for (int n = 0; n < 3; n++) begin
            chk(32'(stat(2'(n))), 32'({out_i[n], 7'h30}));
        end
        $display("test reset done");
        // Control word table, status live and over the bus
        foreach (rows[i]) begin
            wb(1'b1, `OFS_CTRL, 32'(rows[i].cmd), 4'hf);
            chk(32'(stat(rows[i].ch)), 32'({out_i[rows[i].ch], rows[i].exp}));
            wb(1'b0, `OFS_STAT0 + {2'h0, rows[i].ch, 2'h0}, 32'h0, 4'hf);
            chk(32'(q[8:0]), 32'({2'b00, out_i[rows[i].ch], rows[i].exp}));
            pulse_load(3'b001 << rows[i].ch);
            chk(32'(stat(rows[i].ch)), 32'({out_i[rows[i].ch], 1'b0, rows[i].exp[5:0]}));
        end
        $display("test control table done");
        // Latch command, junk low bits, second latch ignored while held
        s = status1_o;
        count_i[31:16] <= 16'h1234;
        wb(1'b1, `OFS_CTRL, 32'h4f, 4'hf);
        chk(32'(status1_o), 32'(s));
        count_i[31:16] <= 16'h9999;
        wb(1'b1, `OFS_CTRL, 32'h40, 4'hf);
        count_i[31:16] <= 16'h5678;
        wb(1'b0, `OFS_CNT1, 32'h0, 4'hf);
        chk(32'(q[16:0]), {15'h0, 17'h11234});
        wb(1'b0, `OFS_CNT1, 32'h0, 4'hf);
        chk(32'(q[16:0]), {15'h0, 17'h05678});
        $display("test latch done");
        // Read-back of counts for counters 0 and 2 only
        count_i <= 48'haaaa_bbbb_cccc;
        @(posedge clk_i);
        snap = {status2_o, status1_o, status0_o};
        wb(1'b1, `OFS_CTRL, 32'hd4, 4'hf);
        chk(32'(snap), 32'({status2_o, status1_o, status0_o}));
        count_i <= 48'h0;
        wb(1'b0, `OFS_CNT0, 32'h0, 4'hf);
        chk(32'(q[16:0]), {15'h0, 17'h1cccc});
        wb(1'b0, `OFS_CNT1, 32'h0, 4'hf);
        chk(32'(q[16:0]), 32'h0);
        wb(1'b0, `OFS_CNT2, 32'h0, 4'hf);
        chk(32'(q[16:0]), {15'h0, 17'h1aaaa});
        // Counter 1 alone, counter 0 left live
        count_i <= 48'h0004_0005_0006;
        wb(1'b1, `OFS_CTRL, 32'hda, 4'hf);
        count_i <= 48'h0;
        wb(1'b0, `OFS_CNT1, 32'h0, 4'hf);
        chk(32'(q[16:0]), {15'h0, 17'h10005});
        wb(1'b0, `OFS_CNT0, 32'h0, 4'hf);
        chk(32'(q[16:0]), 32'h0);
        $display("test readback count done");
        // Read-back of status for counter 1, then a count write sets null
        s = status1_o;
        wb(1'b1, `OFS_CTRL, 32'hea, 4'hf);
        out_i <= out_i ^ 3'b010;
        wr_seen = 0;
        wb(1'b1, `OFS_CNT1, 32'h55, 4'hf);
        chk(32'(wr_seen), 32'h1);
        wb(1'b0, `OFS_STAT1, 32'h0, 4'hf);
        chk(32'(q[8:0]), 32'({1'b1, s}));
        wb(1'b0, `OFS_STAT1, 32'h0, 4'hf);
        chk(32'(q[8:0]), 32'({2'b00, out_i[1], 1'b1, s[5:0]}));
        wb(1'b0, `OFS_CNT1, 32'h0, 4'hf);
        chk(32'(q[16]), 32'h0);
        $display("test readback status done");
        // Low byte disabled write is ignored; unmapped and misaligned refused
        s = status2_o;
        wb(1'b1, `OFS_CTRL, 32'h96, 4'he);
        chk(32'(status2_o), 32'(s));
        wb(1'b0, 6'h20, 32'h0, 4'hf);
        chk(32'(e), 32'h1);
        wb(1'b0, 6'h02, 32'h0, 4'hf);
        chk(32'(e), 32'h1);
        // Spare byte written and read back
        wb(1'b1, `OFS_CFG, 32'ha5, 4'hf);
        chk(32'(cfg_o), 32'ha5);
        wb(1'b0, `OFS_CFG, 32'h0, 4'hf);
        chk(q, 32'h0000_00a5);
        $display("test refusals done");
        tally_and_finish();
    end
endmodule
